// file: src/swmc_top.sv
// Summary of operation
// [R1] Mapped mode write protects each 32 KB logical block via its map entry.
// [R2] Unmapped mode protects 512-word pages from sixteen 16-bit registers; code covers only the low 128 KB, so only registers 0-3 take effect.
// [R3] Privileged state overrides all write protection.
// [R4] Branches write their effective address into bits 13-30.
// [R5] Indirect branches also copy indirect word bits 1-4 to the flags.
// [R6] Bit 0 is the privileged flag, one means privileged.
// [R7] Bits 1-4 hold condition flags one through four.
// [R8] Bit 5 is long indexing, bit 7 enables arithmetic exception trap.
// [R9] Bit 30 marks next right half; saved word bit 6 records it.
// [R10] Bits 8, 9 and 31 appear only in the displayed word.
// [R11] Program counter bits 10-29; bits 10-12 are zero.
// [R12] Bits 32-33 zero means unmapped, otherwise mapped.
// [R13] Bits 34-46 give base process index, bit 46 ignored.
// [R14] Bit 47 in a new word keeps the map contents.
// [R15] Bits 48-49: unblocked, blocked, or keep present blocking.
// [R16] Bits 50-63 give current process index, bits 62-63 ignored.
// [R17] Most instructions store flags: exception, above, below, equal zero.
// [R18] Reset loads scratchpad cell with the 24-bit process list base.
// [R19] Software process entries hold descriptor list address and 6-bit count.
// [R20] Unmapped load leaves map untouched and inactive, beating change load.
// [R21] Plain load only reactivates the map without reloading.
// [R22] Other loads rebuild map entries from page 0 upward, at most 32.
// [R23] Rebuild appends each segment's pages until the count is spent.
// [R24] Borrow flag takes first descriptor from base list, rest current.
// [R25] Unprivileged write to protected area is blocked and flagged.
module swmc_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // New status doubleword load
  input  wire logic                 ld_valid,
  input  wire swmc_pkg::swmc_load_e ld_kind,
  input  wire logic [63:0]          ld_word,
  // Branch update
  input  wire logic                 br_valid,
  input  wire logic [17:0]          br_addr,
  input  wire logic                 br_indirect,
  input  wire logic [3:0]           br_ind_cc,
  // Instruction completion
  input  wire logic                 cc_valid,
  input  wire swmc_pkg::swmc_cc_s   cc_in,
  input  wire logic                 next_rh_in,
  input  wire logic                 ext_arith_exc,
  // Saved word request
  input  wire logic                 sav_req,
  // Page protect register write
  input  wire logic                 pp_we,
  input  wire logic [3:0]           pp_idx,
  input  wire logic [15:0]          pp_data,
  // Scratchpad write of process list base
  input  wire logic                 pl_base_we,
  input  wire logic [23:0]          pl_base_in,
  // Table memory read port
  output swmc_pkg::swmc_mreq_s      mem_req,
  input  wire logic                 mem_ack,
  input  wire logic [31:0]          mem_rdata,
  // Protection check
  input  wire logic                 wr_req,
  input  wire logic [23:0]          wr_addr,
  output logic                      wr_allow,
  output logic                      wr_violate,
  // Status view
  output logic [63:0]               disp_word,
  output logic [63:0]               saved_word,
  output logic                      xlat_active,
  output logic                      rebuild_busy,
  output logic                      arith_trap,
  output logic [15:0]               map_rdata,
  input  wire logic [4:0]           map_ridx
);
  typedef enum logic [2:0] {
    S_IDLE, S_CTRL, S_SDESC, S_IMAGE, S_FILL
  } swmc_st_e;

  logic [63:0] psd_q;
  logic        blocked_q;
  logic        xlat_on_q;
  logic [23:0] pl_base_q;
  logic [15:0] pp_q [swmc_pkg::PROT_REGS];
  logic [15:0] map_q [swmc_pkg::MAP_ENTRIES];
  logic [63:0] saved_q;
  swmc_st_e    st_q;
  logic [5:0]  seg_left_q;
  logic [23:0] sdl_ptr_q;
  logic [23:0] img_ptr_q;
  logic [5:0]  pg_left_q;
  logic [5:0]  fill_q;
  logic        borrow_q;
  logic        use_base_q;
  logic        half_q;
  logic [31:0] img_q;
  logic        arith_trap_q;

  // Map a printed bit number to the vector index
  function automatic logic [5:0] bp(input int n);
    return swmc_pkg::swmc_bit(n);
  endfunction : bp

  wire logic mapped = psd_q[bp(swmc_pkg::POS_GRAN_LO)] |
                      psd_q[bp(swmc_pkg::POS_GRAN_LO+1)]; // [R12]
  wire logic privileged_state   = psd_q[bp(swmc_pkg::POS_PRIVILEGED_STATE)]; // [R6]
  wire logic new_mapped = ld_word[bp(swmc_pkg::POS_GRAN_LO)] |
                          ld_word[bp(swmc_pkg::POS_GRAN_LO+1)];
  wire logic [11:0] base_process_index = psd_q[bp(swmc_pkg::POS_BASE_PROCESS_INDEX_LO):
                                 bp(swmc_pkg::POS_BASE_PROCESS_INDEX_HI)]; // [R13]
  wire logic [11:0] current_process_index = psd_q[bp(swmc_pkg::POS_CURRENT_PROCESS_INDEX_LO):
                                 bp(swmc_pkg::POS_CURRENT_PROCESS_INDEX_HI)]; // [R16]
  wire logic start_rebuild = ld_valid && st_q == S_IDLE && new_mapped &&
    ld_kind != swmc_pkg::SWMC_LD_PLAIN &&
    !ld_word[bp(swmc_pkg::POS_RETAIN)];
  // Rebuild ends on the last page, on a full map or on an empty chain;
  // odd page counts end on an even half, so half_q cannot mark the end
  wire logic walk_end =
    (st_q == S_FILL && ((fill_q == 6'd31 && pg_left_q != 6'd0) ||
      (pg_left_q <= 6'd1 && seg_left_q == 6'd0))) ||
    (st_q == S_CTRL && mem_ack && !use_base_q && !mem_rdata[31] &&
      mem_rdata[29:24] == 6'd0);

  // Program status doubleword
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psd_q <= {swmc_pkg::SW1_RESET, swmc_pkg::SW2_RESET};
    end else if (ld_valid && st_q == S_IDLE) begin
      psd_q <= ld_word;
      psd_q[bp(swmc_pkg::POS_PC_LO):bp(swmc_pkg::POS_ADDR_LO-1)] <= 3'b000; // [R11]
      psd_q[bp(swmc_pkg::POS_DW_MODE)] <= 1'b0; // [R10]
      psd_q[bp(swmc_pkg::POS_XLAT_ON)] <= 1'b0;
      psd_q[bp(swmc_pkg::POS_BLOCKED)] <= 1'b0;
      psd_q[bp(swmc_pkg::POS_PREV_RH)] <= 1'b0; // [R9]
    end else if (br_valid) begin
      psd_q[bp(swmc_pkg::POS_ADDR_LO):bp(swmc_pkg::POS_NEXT_RH)] <= br_addr; // [R4]
      if (br_indirect) begin
        psd_q[bp(swmc_pkg::POS_CC_LO):bp(swmc_pkg::POS_CC_HI)] <= br_ind_cc; // [R5]
      end
    end else if (cc_valid) begin
      psd_q[bp(1)] <= cc_in.aexc; // [R17] [R7]
      psd_q[bp(2)] <= cc_in.gt;
      psd_q[bp(3)] <= cc_in.lt;
      psd_q[bp(4)] <= cc_in.eq;
      psd_q[bp(swmc_pkg::POS_NEXT_RH)] <= next_rh_in; // [R9]
    end
  end

  // Interrupt blocking state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blocked_q <= 1'b0;
    end else if (ld_valid && st_q == S_IDLE &&
                 !ld_word[bp(swmc_pkg::POS_INT_LO)]) begin
      blocked_q <= ld_word[bp(swmc_pkg::POS_INT_LO+1)]; // [R15]
    end
  end

  // Translation active flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xlat_on_q <= 1'b0;
    end else if (ld_valid && st_q == S_IDLE) begin
      // Unmapped wins over any load kind; rebuild enables on completion
      xlat_on_q <= new_mapped && !start_rebuild; // [R20] [R21] [R14]
    end else if (walk_end) begin
      xlat_on_q <= 1'b1; // [R22]
    end
  end

  // Arithmetic exception trap, raised only when masked on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arith_trap_q <= 1'b0;
    end else begin
      arith_trap_q <= ext_arith_exc && psd_q[bp(swmc_pkg::POS_TRAPMASK)]; // [R8]
    end
  end

  // Saved status word keeps the last right-half marker in bit 6
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      saved_q <= 64'h0000_0000_0000_0000;
    end else if (sav_req) begin
      saved_q <= psd_q;
      saved_q[bp(swmc_pkg::POS_PREV_RH)] <=
        psd_q[bp(swmc_pkg::POS_NEXT_RH)]; // [R9]
    end
  end

  // Scratchpad cell for the process list base
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pl_base_q <= swmc_pkg::PL_BASE_RESET; // [R18]
    end else if (pl_base_we) begin
      pl_base_q <= pl_base_in;
    end
  end

  // Page protect registers
  generate
    for (genvar g = 0; g < swmc_pkg::PROT_REGS; g++) begin : g_pp
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pp_q[g] <= 16'h0000;
        end else if (pp_we && pp_idx == 4'(g)) begin
          pp_q[g] <= pp_data; // [R2]
        end
      end
    end
  endgenerate

  // Table walk; entry fields: bit 31 borrow, 29:24 count, 23:0 pointer
  wire logic [23:0] idx_addr = pl_base_q +
    {10'h000, (use_base_q ? base_process_index : current_process_index), 2'b00};
  always_comb begin
    mem_req = '0;
    unique case (st_q)
      S_CTRL:  mem_req = '{valid: 1'b1, addr: idx_addr, is_write: 1'b0};
      S_SDESC: mem_req = '{valid: 1'b1, addr: sdl_ptr_q, is_write: 1'b0};
      S_IMAGE: mem_req = '{valid: 1'b1, addr: img_ptr_q, is_write: 1'b0};
      default: mem_req = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= S_IDLE;
      seg_left_q <= 6'd0;
      sdl_ptr_q  <= 24'h00_0000;
      img_ptr_q  <= 24'h00_0000;
      pg_left_q  <= 6'd0;
      fill_q     <= 6'd0;
      borrow_q   <= 1'b0;
      use_base_q <= 1'b0;
      half_q     <= 1'b0;
      img_q      <= 32'h0000_0000;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          if (start_rebuild) begin
            st_q       <= S_CTRL; // [R22]
            fill_q     <= 6'd0;
            use_base_q <= 1'b0;
          end
        end
        S_CTRL: if (mem_ack) begin
          if (!use_base_q && mem_rdata[31]) begin
            // Borrow: first descriptor from base list, count from current
            borrow_q   <= 1'b1; // [R24] [R19]
            seg_left_q <= mem_rdata[29:24] - 6'd1;
            sdl_ptr_q  <= mem_rdata[23:0];
            use_base_q <= 1'b1;
          end else if (use_base_q) begin
            // Base list supplies its first descriptor
            st_q      <= S_SDESC; // [R24]
            img_ptr_q <= sdl_ptr_q;
            sdl_ptr_q <= mem_rdata[23:0];
          end else begin
            borrow_q   <= 1'b0;
            seg_left_q <= mem_rdata[29:24];
            sdl_ptr_q  <= mem_rdata[23:0];
            st_q       <= (mem_rdata[29:24] == 6'd0) ? S_IDLE : S_SDESC;
          end
        end
        S_SDESC: if (mem_ack) begin
          pg_left_q <= mem_rdata[29:24]; // [R23]
          img_ptr_q <= mem_rdata[23:0];
          if (use_base_q) begin
            sdl_ptr_q  <= img_ptr_q;
            use_base_q <= 1'b0;
          end else begin
            sdl_ptr_q  <= sdl_ptr_q + 24'd4;
            seg_left_q <= seg_left_q - 6'd1;
          end
          half_q <= 1'b0;
          st_q   <= (mem_rdata[29:24] == 6'd0) ? S_FILL : S_IMAGE;
        end
        S_IMAGE: if (mem_ack) begin
          img_q     <= mem_rdata;
          img_ptr_q <= img_ptr_q + 24'd4;
          st_q      <= S_FILL;
        end
        S_FILL: begin
          // One halfword page entry per cycle, even half first
          if (pg_left_q != 6'd0) begin
            fill_q    <= fill_q + 6'd1; // [R23]
            pg_left_q <= pg_left_q - 6'd1;
            half_q    <= !half_q;
          end
          if (fill_q == 6'd31 && pg_left_q != 6'd0) begin
            st_q <= S_IDLE;
          end else if (pg_left_q <= 6'd1) begin
            st_q <= (seg_left_q == 6'd0) ? S_IDLE : S_SDESC;
          end else if (half_q) begin
            st_q <= S_IMAGE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Map RAM; entries past a short segment chain are left as they were
  generate
    for (genvar m = 0; m < swmc_pkg::MAP_ENTRIES; m++) begin : g_map
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          map_q[m] <= 16'h0000;
        end else if (st_q == S_FILL && pg_left_q != 6'd0 &&
                     fill_q == 6'(m)) begin
          map_q[m] <= half_q ? img_q[15:0] : img_q[31:16]; // [R22]
        end
      end
    end
  endgenerate

  logic [31:0]  map_prot;
  logic [255:0] page_prot;
  always_comb begin
    for (int i = 0; i < swmc_pkg::MAP_ENTRIES; i++) begin
      map_prot[i] = map_q[i][swmc_pkg::ENT_PROT];
    end
    for (int j = 0; j < swmc_pkg::PROT_REGS; j++) begin
      page_prot[j*16 +: 16] = pp_q[j];
    end
  end

  swmc_prot u_prot (
    .wr_req     (wr_req),
    .byte_addr  (wr_addr),
    .mapped     (xlat_on_q && mapped),
    .privileged (privileged_state),
    .map_prot   (map_prot),
    .page_prot  (page_prot),
    .wr_allow   (wr_allow),
    .wr_violate (wr_violate)
  );

  // Displayed word carries mode flags that the stored word does not
  always_comb begin
    disp_word = psd_q;
    disp_word[bp(swmc_pkg::POS_DW_MODE)] = 1'b1; // [R10]
    disp_word[bp(swmc_pkg::POS_XLAT_ON)] = xlat_on_q;
    disp_word[bp(swmc_pkg::POS_BLOCKED)] = blocked_q;
  end

  assign saved_word   = saved_q;
  assign xlat_active  = xlat_on_q;
  assign rebuild_busy = st_q != S_IDLE;
  assign arith_trap   = arith_trap_q;
  assign map_rdata    = map_q[map_ridx];

  property p_privileged_state_override;
    @(posedge clk) disable iff (!rst_n)
      (wr_req && privileged_state) |-> wr_allow;
  endproperty
  a_privileged_state_override: assert property (p_privileged_state_override) // [R3]
    else $error("privileged write blocked");

  property p_branch_pc;
    @(posedge clk) disable iff (!rst_n)
      (br_valid && !(ld_valid && st_q == S_IDLE)) |=>
        psd_q[bp(13):bp(30)] == $past(br_addr);
  endproperty
  a_branch_pc: assert property (p_branch_pc) // [R4]
    else $error("branch address not stored");

  property p_unmapped_load;
    @(posedge clk) disable iff (!rst_n)
      (ld_valid && st_q == S_IDLE && !new_mapped) |=>
        !xlat_on_q && st_q == S_IDLE;
  endproperty
  a_unmapped_load: assert property (p_unmapped_load) // [R20]
    else $error("unmapped load touched map");

  property p_plain_load;
    @(posedge clk) disable iff (!rst_n)
      (ld_valid && st_q == S_IDLE && new_mapped &&
       ld_kind == swmc_pkg::SWMC_LD_PLAIN) |=> xlat_on_q && st_q == S_IDLE;
  endproperty
  a_plain_load: assert property (p_plain_load) // [R21]
    else $error("plain load did not just reactivate");

  property p_rebuild_start;
    @(posedge clk) disable iff (!rst_n)
      start_rebuild |=> st_q == S_CTRL && fill_q == 6'd0 && !xlat_on_q;
  endproperty
  a_rebuild_start: assert property (p_rebuild_start) // [R22]
    else $error("rebuild did not start at page 0");

  property p_violate;
    @(posedge clk) disable iff (!rst_n)
      wr_violate |-> !wr_allow && !privileged_state;
  endproperty
  a_violate: assert property (p_violate) // [R25]
    else $error("violation with write allowed");

  property p_trap_mask;
    @(posedge clk) disable iff (!rst_n)
      arith_trap |-> $past(psd_q[bp(7)]) && $past(ext_arith_exc);
  endproperty
  a_trap_mask: assert property (p_trap_mask) // [R8]
    else $error("trap raised while masked");

  property p_pc_reserved;
    @(posedge clk) disable iff (!rst_n)
      $rose(ld_valid && st_q == S_IDLE) |=> psd_q[bp(10):bp(12)] == 3'b000;
  endproperty
  a_pc_reserved: assert property (p_pc_reserved) // [R11]
    else $error("reserved pc bits nonzero");

  property p_block_keep;
    @(posedge clk) disable iff (!rst_n)
      (ld_valid && st_q == S_IDLE && ld_word[bp(48)]) |=> $stable(blocked_q);
  endproperty
  a_block_keep: assert property (p_block_keep) // [R15]
    else $error("blocking state not retained");
endmodule : swmc_top

// file: src/swmc_pkg.sv
package swmc_pkg;
  // Status doubleword bit positions, bit 0 is the most significant bit
  // of the first word as printed; stored here as index 63-n.
  localparam int POS_PRIVILEGED_STATE      = 0;
  localparam int POS_CC_LO     = 1;
  localparam int POS_CC_HI     = 4;
  localparam int POS_LONG_IDX  = 5;
  localparam int POS_PREV_RH   = 6;
  localparam int POS_TRAPMASK  = 7;
  localparam int POS_DW_MODE   = 8;
  localparam int POS_XLAT_ON   = 9;
  localparam int POS_PC_LO     = 10;
  localparam int POS_ADDR_LO   = 13;
  localparam int POS_PC_HI     = 29;
  localparam int POS_NEXT_RH   = 30;
  localparam int POS_BLOCKED   = 31;
  localparam int POS_GRAN_LO   = 32;
  localparam int POS_BASE_PROCESS_INDEX_LO   = 34;
  localparam int POS_BASE_PROCESS_INDEX_HI   = 45;
  localparam int POS_RETAIN    = 47;
  localparam int POS_INT_LO    = 48;
  localparam int POS_CURRENT_PROCESS_INDEX_LO   = 50;
  localparam int POS_CURRENT_PROCESS_INDEX_HI   = 61;

  localparam int MAP_ENTRIES   = 32;
  localparam int PROT_REGS     = 16;
  localparam int PROT_PAGES    = 256;
  localparam int PAGE_WORDS    = 512;
  localparam int BLOCK_BYTES   = 32768;
  localparam int ADDR_W        = 24;
  localparam int SDC_W         = 6;

  // Byte address of the scratchpad cell holding the process list base
  localparam logic [7:0]  SCRATCH_CELL   = 8'h83;
  localparam logic [23:0] PL_BASE_RESET  = 24'h00_0000;
  localparam logic [31:0] SW1_RESET      = 32'h0000_0000;
  localparam logic [31:0] SW2_RESET      = 32'h0000_0000;
  // Map entry layout: bit 15 valid, bit 14 write protect, 11:0 page
  localparam int ENT_VALID = 15;
  localparam int ENT_PROT  = 14;

  typedef enum logic [1:0] {
    SWMC_LD_PLAIN,
    SWMC_LD_CHANGE,
    SWMC_LD_OTHER
  } swmc_load_e;

  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic        is_write;
  } swmc_mreq_s;

  typedef struct packed {
    logic        gt;
    logic        lt;
    logic        eq;
    logic        aexc;
  } swmc_cc_s;

  function automatic logic [5:0] swmc_bit(input int n);
    return 6'(63 - n);
  endfunction : swmc_bit
endpackage : swmc_pkg

// file: src/swmc_prot.sv
// Write-protect decision for one access in mapped or unmapped mode
module swmc_prot (
  // Access
  input  wire logic        wr_req,
  input  wire logic [23:0] byte_addr,
  input  wire logic        mapped,
  input  wire logic        privileged,
  // Protect sources
  input  wire logic [31:0] map_prot,
  input  wire logic [255:0] page_prot,
  // Result
  output logic             wr_allow,
  output logic             wr_violate
);
  logic prot_hit;
  always_comb begin
    prot_hit = 1'b0;
    if (mapped) begin
      // 32 KB block index from the 19-bit logical address plus extended bit
      prot_hit = map_prot[byte_addr[19:15]]; // [R1]
    end else if (byte_addr[23:17] == 7'h00) begin
      // 512-word pages of 2 KB; only the low 32K words (128 KB) are coverable
      prot_hit = page_prot[byte_addr[18:11]]; // [R2]
    end
    wr_allow   = wr_req && (!prot_hit || privileged); // [R3]
    wr_violate = wr_req && prot_hit && !privileged; // [R25]
  end
endmodule : swmc_prot

// file: sim/swmc_mem_model.sv
// Table memory behind the rebuild port; latency steps 0,1,2 in turn
module swmc_mem_model (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Table read port
  input  wire swmc_pkg::swmc_mreq_s mem_req,
  output logic                      mem_ack,
  output logic [31:0]               mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Entries and descriptors keep the software layout set by the bench
  logic [31:0] mem [logic [23:0]];
  int          wait_cnt;
  int          lat;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h5555_aaaa;
      wait_cnt  <= 0;
      lat       <= 0;
    end else if (mem_req.valid && !mem_ack && wait_cnt >= lat) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem.exists(mem_req.addr) ? mem[mem_req.addr] : 32'h0;
      wait_cnt  <= 0;
      lat       <= (lat + 1) % 3;
    end else begin
      mem_ack   <= 1'b0;
      // Data is gone once the answer is over, so stale reads show up
      mem_rdata <= ~mem_rdata;
      if (mem_req.valid && !mem_ack) begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule : swmc_mem_model

// file: sim/swmc_top_bench.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module swmc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk, rst_n, ld_valid, br_valid, br_indirect;
  logic                 cc_valid, next_rh_in, ext_arith_exc, sav_req;
  logic                 pp_we, pl_base_we, mem_ack, wr_req;
  logic                 wr_allow, wr_violate, xlat_active, rebuild_busy;
  logic                 arith_trap;
  swmc_pkg::swmc_load_e ld_kind;
  swmc_pkg::swmc_cc_s   cc_in;
  swmc_pkg::swmc_mreq_s mem_req;
  logic [63:0]          ld_word, disp_word, saved_word, w;
  logic [17:0]          br_addr;
  logic [3:0]           br_ind_cc, pp_idx;
  logic [15:0]          pp_data, map_rdata;
  logic [23:0]          pl_base_in, wr_addr;
  logic [31:0]          mem_rdata;
  logic [4:0]           map_ridx;
  int                   errors, compares;

  swmc_top swmc_top_inst (.clk(clk), .rst_n(rst_n), .ld_valid(ld_valid),
    .ld_kind(ld_kind), .ld_word(ld_word), .br_valid(br_valid),
    .br_addr(br_addr), .br_indirect(br_indirect), .br_ind_cc(br_ind_cc),
    .cc_valid(cc_valid), .cc_in(cc_in), .next_rh_in(next_rh_in),
    .ext_arith_exc(ext_arith_exc), .sav_req(sav_req), .pp_we(pp_we),
    .pp_idx(pp_idx), .pp_data(pp_data), .pl_base_we(pl_base_we),
    .pl_base_in(pl_base_in), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_allow(wr_allow), .wr_violate(wr_violate), .disp_word(disp_word),
    .saved_word(saved_word), .xlat_active(xlat_active),
    .rebuild_busy(rebuild_busy), .arith_trap(arith_trap),
    .map_rdata(map_rdata), .map_ridx(map_ridx));
  swmc_mem_model swmc_mem_model_inst (.clk(clk), .rst_n(rst_n),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #2 clk = ~clk;

  // Printed bit a is the most significant of an n-bit field
  function automatic logic [63:0] fld(logic [63:0] x, int a, int n,
                                      logic [17:0] v);
    for (int i = 0; i < n; i++) x[63-a-i] = v[n-1-i];
    return x;
  endfunction : fld

  function automatic logic [63:0] mk(logic p, logic [1:0] g, logic [11:0] b,
                                     logic [11:0] c);
    return fld(fld(fld(fld(64'h0, 0, 1, p), 32, 2, g), 34, 12, b), 50, 12, c);
  endfunction : mk

  task automatic finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic put(logic [23:0] a, logic [31:0] d);
    swmc_mem_model_inst.mem[a] = d;
  endtask : put

  task automatic ld(swmc_pkg::swmc_load_e k, logic [63:0] x);
    @(posedge clk);
    ld_valid <= 1'b1;
    ld_kind  <= k;
    ld_word  <= x;
    @(posedge clk);
    ld_valid <= 1'b0;
    #1;
  endtask : ld

  task automatic rebuild(logic [63:0] x);
    ld(swmc_pkg::SWMC_LD_OTHER, x);
    `CHK(rebuild_busy, 1'b1)
    for (int i = 0; i < 3000 && rebuild_busy !== 1'b0; i++) @(posedge clk);
    #1;
    `CHK(rebuild_busy, 1'b0)
    `CHK(xlat_active, 1'b1)
  endtask : rebuild

  task automatic no_busy;
    repeat (4) begin
      @(posedge clk);
      #1;
      `CHK(rebuild_busy, 1'b0)
    end
  endtask : no_busy

  task automatic chk_map(logic [4:0] i, logic [15:0] e);
    @(posedge clk);
    map_ridx <= i;
    #1;
    `CHK(map_rdata, e)
  endtask : chk_map

  task automatic prot(logic [23:0] a, logic ok);
    @(posedge clk);
    wr_req  <= 1'b1;
    wr_addr <= a;
    #1;
    `CHK(wr_allow, ok)
    `CHK(wr_violate, ~ok)
  endtask : prot

  task automatic t_reset;
    `CHK(disp_word, 64'h0080_0000_0000_0000)
    `CHK(xlat_active, 1'b0)
    `CHK(map_rdata, 16'h0000)
  endtask : t_reset

  task automatic t_fields;
    logic [1:0] code [5] = '{2'b01, 2'b10, 2'b11, 2'b00, 2'b11};
    logic       blk [5]  = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    w = fld(fld(fld(mk(1'b1, 2'b00, 12'h0, 12'h0), 1, 4, 4'ha), 5, 1, 1), 7, 1, 1);
    w = fld(fld(w, 13, 17, 18'h1_2345), 48, 2, 2'b01);
    ld(swmc_pkg::SWMC_LD_CHANGE, w);
    `CHK(disp_word, fld(fld(w, 8, 1, 1), 31, 1, 1))
    `CHK(rebuild_busy, 1'b0)
    `CHK(xlat_active, 1'b0)
    @(posedge clk);
    ext_arith_exc <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(arith_trap, 1'b1)
    for (int i = 0; i < 5; i++) begin
      ld(swmc_pkg::SWMC_LD_OTHER, fld(mk(1'b1, 2'b00, 12'h0, 12'h0), 48, 2, code[i]));
      `CHK(disp_word[63-31], blk[i])
    end
    `CHK(arith_trap, 1'b0)
    @(posedge clk);
    ext_arith_exc <= 1'b0;
  endtask : t_fields

  task automatic t_branch;
    @(posedge clk);
    br_valid    <= 1'b1;
    br_indirect <= 1'b1;
    br_addr     <= 18'h2_abcd;
    br_ind_cc   <= 4'b0110;
    @(posedge clk);
    br_valid <= 1'b0;
    #1;
    `CHK(disp_word[63-13 -: 18], 18'h2_abcd)
    `CHK(disp_word[62 -: 4], 4'b0110)
    @(posedge clk);
    cc_valid   <= 1'b1;
    cc_in      <= '{gt: 1'b1, lt: 1'b0, eq: 1'b0, aexc: 1'b1};
    next_rh_in <= 1'b1;
    @(posedge clk);
    cc_valid <= 1'b0;
    sav_req  <= 1'b1;
    @(posedge clk);
    sav_req <= 1'b0;
    #1;
    `CHK(disp_word[62 -: 4], 4'b1100)
    `CHK(disp_word[63-30], 1'b1)
    `CHK(saved_word[63-6], 1'b1)
    `CHK(disp_word[63-10 -: 3], 3'b000)
  endtask : t_branch

  task automatic t_map;
    @(posedge clk);
    pl_base_we <= 1'b1;
    pl_base_in <= 24'h00_1000;
    @(posedge clk);
    pl_base_we <= 1'b0;
    put(24'h00_1008, 32'h0200_2000);
    put(24'h00_2000, 32'h0200_3000);
    put(24'h00_2004, 32'h0400_4000);
    put(24'h00_3000, 32'h8010_c011);
    put(24'h00_4000, 32'h8012_8013);
    put(24'h00_4004, 32'h8014_8015);
    rebuild(mk(1'b0, 2'b01, 12'h0, 12'h2));
    `CHK(disp_word[63-9], 1'b1)
    chk_map(5'd0, 16'h8010);
    chk_map(5'd1, 16'hc011);
    for (int i = 2; i < 6; i++) chk_map(5'(i), 16'(16'h8010 + i));
    prot(24'h00_8000, 1'b0);
    prot(24'h00_0000, 1'b1);
    ld(swmc_pkg::SWMC_LD_PLAIN, mk(1'b1, 2'b01, 12'h0, 12'h2));
    no_busy();
    `CHK(xlat_active, 1'b1)
    prot(24'h00_8000, 1'b1);
    put(24'h00_3000, 32'h8030_c031);
    ld(swmc_pkg::SWMC_LD_OTHER, fld(mk(1'b0, 2'b11, 12'h0, 12'h2), 47, 1, 1));
    no_busy();
    chk_map(5'd0, 16'h8010);
    ld(swmc_pkg::SWMC_LD_CHANGE, mk(1'b0, 2'b00, 12'h0, 12'h2));
    no_busy();
    `CHK(xlat_active, 1'b0)
    chk_map(5'd0, 16'h8010);
    @(posedge clk);
    pp_we   <= 1'b1;
    pp_idx  <= 4'd1;
    pp_data <= 16'h0004;
    @(posedge clk);
    pp_we <= 1'b0;
    prot(24'h00_9000, 1'b0);
    prot(24'h00_9800, 1'b1);
    @(posedge clk);
    wr_req <= 1'b0;
  endtask : t_map

  task automatic t_borrow;
    put(24'h00_1004, 32'h0100_6000);
    put(24'h00_100c, 32'h8200_5000);
    put(24'h00_6000, 32'h0200_7000);
    put(24'h00_5000, 32'h0200_8000);
    put(24'h00_7000, 32'h8020_8021);
    put(24'h00_8000, 32'h8022_8023);
    rebuild(mk(1'b0, 2'b10, 12'h1, 12'h3));
    for (int i = 0; i < 4; i++) chk_map(5'(i), 16'(16'h8020 + i));
  endtask : t_borrow

  initial begin
    clk = 0; rst_n = 0; ld_valid = 0; ld_kind = swmc_pkg::SWMC_LD_PLAIN;
    ld_word = '0; br_valid = 0; br_addr = '0; br_indirect = 0;
    br_ind_cc = '0; cc_valid = 0; cc_in = '0; next_rh_in = 0;
    ext_arith_exc = 0; sav_req = 0; pp_we = 0; pp_idx = '0; pp_data = '0;
    pl_base_we = 0; pl_base_in = '0; wr_req = 0; wr_addr = '0;
    map_ridx = '0; errors = 0; compares = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_fields();
    t_branch();
    t_map();
    t_borrow();
    finish_test();
  end

  // Whole run is well under 50k cycles; this cuts a hang short
  initial begin
    #200_000;
    errors++;
    finish_test();
  end
endmodule : swmc_top_bench
